// ### shared/repeater_status_defines.svh
// Offsets, page and cause codes and reset values of the repeater status registers
`ifndef REPEATER_STATUS_DEFINES_SVH
`define REPEATER_STATUS_DEFINES_SVH
// Contract
// R1: Chip status D1 reads low while any port sees a collision.
// R2: Chip status D2 reads low while one of our ports is receiving.
// R3: Chip status D3 reads low while the chip is in babble lock.
// R4: Chip status D4 reads low while any port is isolated.
// R5: Chip status D0 always reads zero.
// R6: Chip status D5 and D6 show the selected transceiver interface.
// R7: Chip status D7 shows bus signal polarity, one meaning active low.
// R8: Port status D0 reads zero while link pulses arrive, else one.
// R9: Writing one to port D0 stops link pulse sending and monitoring.
// R10: Link bit is undefined on port 1 and without internal transceivers.
// R11: Port status D1 shows a collision during the current packet.
// R12: Port status D2 shows the port was the receive source.
// R13: Port status D3 reads zero while isolated, one while connected.
// R14: Writing one to port D3 forces reconnection; zero does nothing.
// R15: Port status D5 and D4 hold the isolation cause code.
// R16: Cause codes: 00 collisions, 01 long collision, 10 loopback, 11 forced.
// R17: Port status D7 set blocks all port activity.
// R18: Page select low three bits choose the page at 11H to 1FH.
// R19: Event counters read low byte at even, high byte at odd offset.

// ****************************************
// Register indexes, byte address is four times these
// ****************************************
`define IDX_CHIP_STATUS 5'h00
`define IDX_PORT_FIRST 5'h01
`define IDX_PORT_LAST 5'h0d
`define IDX_PAGE_SELECT 5'h10
`define IDX_RECORD_FIRST 5'h11
`define IDX_RECORD_LAST 5'h1d
`define IDX_COUNT_FIRST 5'h12
`define IDX_COUNT_A_LAST 5'h1f
`define IDX_COUNT_B_LAST 5'h1d

// ****************************************
// Pages, codes and reset values
// ****************************************
`define PAGE_RESET 3'h0
`define PAGE_RECORD 3'h1
`define PAGE_COUNT_A 3'h2
`define PAGE_COUNT_B 3'h3
`define PORTS_ON_PAGE_A 4'h7
`define CAUSE_FORCED 2'h3
`define CAUSE_RESET 2'h0
`define COUNT_FULL 16'hffff
`define PORT_COUNT_MAX 13

`endif

// ### shared/repeater_status_pkg.sv
// Types shared by the repeater status register bank
package repeater_status_pkg;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [6:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_type;

    // Live state of one port from the repeater core
    typedef struct packed {
        logic clash;
        logic rx_source;
        logic isolated;
        logic [1:0] cause;
        logic link_seen;
    } port_live_type;

    // Software controls of one port
    typedef struct packed {
        logic port_off;
        logic port_status_bit6;
        logic link_pulse_off;
        logic reconnect;
    } port_ctl_type;

endpackage

// ### rtl/level_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Levels
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);

    if (WIDTH < 1) begin : g_check
        $error("level_sync needs WIDTH of at least one");
    end

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= level_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign level_out = stage2_ff;

endmodule
`default_nettype wire

// ### rtl/event_tracker.sv
// Per-port event counter and sticky event record
`timescale 1ns/100ps
`default_nettype none
`include "repeater_status_defines.svh"

module event_tracker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Events
    input wire logic count_pulse_in,
    input wire logic [7:0] flags_in,
    // Clears from register reads
    input wire logic clear_record_in,
    input wire logic clear_count_in,
    // State
    output logic [15:0] count_out,
    output logic [7:0] record_out
);

    logic [15:0] count_ff;
    logic [7:0] record_ff;

    // Saturates; an event in the clearing cycle still counts
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_ff <= 16'h0000;
        end else if (clear_count_in) begin
            count_ff <= {15'h0000, count_pulse_in};
        end else if (count_pulse_in && count_ff != `COUNT_FULL) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            record_ff <= 8'h00;
        end else begin
            record_ff <= (clear_record_in ? 8'h00 : record_ff) | flags_in;
        end
    end

    assign count_out = count_ff;
    assign record_out = record_ff;

endmodule
`default_nettype wire

// ### rtl/repeater_status_regs.sv
// Status register bank of the multiport repeater on classic Wishbone
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "repeater_status_defines.svh"

module repeater_status_regs
    import repeater_status_pkg::*;
#(
    parameter int PORT_COUNT = 13
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Wishbone slave
    input wire wb_req_type wb_req_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Repeater core state
    input wire port_live_type [PORT_COUNT-1:0] port_live_in,
    input wire logic babble_lock_in,
    input wire logic [PORT_COUNT-1:0][7:0] record_evt_in,
    input wire logic [PORT_COUNT-1:0] count_evt_in,
    // Configuration pins
    input wire logic [1:0] transceiver_sel_in,
    input wire logic bus_polarity_select_in,
    // Port controls
    output port_ctl_type [PORT_COUNT-1:0] port_ctl_out
);

    if (PORT_COUNT < 1 || PORT_COUNT > `PORT_COUNT_MAX) begin : g_check
        $error("PORT_COUNT must lie between 1 and 13");
    end

    // ****************************************
    // Bus decode
    // ****************************************
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [2:0] page_ff;
    logic hit;
    logic wr_en;
    logic rd_en;
    logic [4:0] idx;

    assign hit = wb_req_in.cyc && wb_req_in.stb;
    assign idx = wb_req_in.adr[6:2];
    // Write lands on the edge where the master sees ack
    assign wr_en = hit && wb_req_in.we && ack_ff && wb_req_in.sel[0];
    // Read side effects share the capture edge, so no event slips between
    assign rd_en = hit && !wb_req_in.we && !ack_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= hit && !ack_ff;
        end
    end

    assign wb_ack_out = ack_ff;
    assign wb_dat_out = dat_ff;

    // ****************************************
    // Pin straps
    // ****************************************
    logic [2:0] strap_sync;

    level_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in({bus_polarity_select_in, transceiver_sel_in}),
        .level_out(strap_sync)
    );

    // ****************************************
    // Address to port mapping
    // ****************************************
    logic [3:0] port_num;
    logic port_valid;
    logic [3:0] rec_port;
    logic rec_valid;
    logic [3:0] cnt_port;
    logic cnt_valid;
    logic cnt_hi;
    logic [4:0] cnt_off;
    logic [4:0] rec_off;
    logic [4:0] port_off_idx;

    always_comb begin
        port_off_idx = idx - `IDX_PORT_FIRST;
        port_num = port_off_idx[3:0];
        port_valid = idx >= `IDX_PORT_FIRST && idx <= `IDX_PORT_LAST
            && 32'(port_num) < PORT_COUNT;
        rec_off = idx - `IDX_RECORD_FIRST;
        rec_port = rec_off[3:0];
        rec_valid = page_ff == `PAGE_RECORD && idx >= `IDX_RECORD_FIRST
            && idx <= `IDX_RECORD_LAST && 32'(rec_port) < PORT_COUNT; // R18
        cnt_off = idx - `IDX_COUNT_FIRST;
        cnt_hi = cnt_off[0]; // R19
        cnt_port = {1'b0, cnt_off[3:1]};
        cnt_valid = 1'b0;
        if (page_ff == `PAGE_COUNT_A) begin
            cnt_valid = idx >= `IDX_COUNT_FIRST && idx <= `IDX_COUNT_A_LAST;
        end else if (page_ff == `PAGE_COUNT_B) begin
            cnt_port = {1'b0, cnt_off[3:1]} + `PORTS_ON_PAGE_A;
            cnt_valid = idx >= `IDX_COUNT_FIRST && idx <= `IDX_COUNT_B_LAST;
        end
        cnt_valid = cnt_valid && 32'(cnt_port) < PORT_COUNT;
    end

    // ****************************************
    // Per-port state
    // ****************************************
    logic [PORT_COUNT-1:0][7:0] status_bytes;
    logic [PORT_COUNT-1:0][7:0] records;
    logic [PORT_COUNT-1:0][15:0] counts;
    logic [PORT_COUNT-1:0] clash_vec;
    logic [PORT_COUNT-1:0] rx_vec;
    logic [PORT_COUNT-1:0] iso_vec;
    logic [PORT_COUNT-1:0] full_vec;
    logic [PORT_COUNT-1:0] half_vec;
    logic [PORT_COUNT-1:0] low_vec;
    logic [PORT_COUNT-1:0] found_vec;
    logic port_wr;

    assign port_wr = wr_en && port_valid;

    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        logic link_off_ff;
        logic off_ff;
        logic bit6_ff;
        logic reconnect_ff;
        logic iso_prev_ff;
        logic [1:0] cause_ff;
        logic sel_wr;
        logic clear_rec;
        logic clear_cnt;

        assign sel_wr = port_wr && 32'(port_num) == p;
        assign clear_rec = rd_en && rec_valid && 32'(rec_port) == p;
        assign clear_cnt = rd_en && cnt_valid && cnt_hi && 32'(cnt_port) == p;

        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                link_off_ff <= 1'b0;
                off_ff <= 1'b0;
                bit6_ff <= 1'b0;
            end else if (sel_wr) begin
                link_off_ff <= wb_req_in.dat[0]; // R9
                off_ff <= wb_req_in.dat[7]; // R17
                bit6_ff <= wb_req_in.dat[6];
            end
        end

        // Zero written to the connect bit is ignored
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                reconnect_ff <= 1'b0;
            end else begin
                reconnect_ff <= sel_wr && wb_req_in.dat[3]; // R14
            end
        end

        // Cause kept from the moment of isolation, forced code on reconnect
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                iso_prev_ff <= 1'b0;
                cause_ff <= `CAUSE_RESET;
            end else begin
                iso_prev_ff <= port_live_in[p].isolated;
                if (reconnect_ff) begin
                    cause_ff <= `CAUSE_FORCED; // R16
                end else if (port_live_in[p].isolated && !iso_prev_ff) begin
                    cause_ff <= port_live_in[p].cause; // R15
                end
            end
        end

        // Link reading is meaningless on the AUI port or external transceivers
        assign status_bytes[p] = {off_ff, bit6_ff, cause_ff, // R15
            !port_live_in[p].isolated, // R13
            port_live_in[p].rx_source, // R12
            port_live_in[p].clash, // R11
            link_off_ff || !port_live_in[p].link_seen}; // R8 R10

        assign port_ctl_out[p] = {off_ff, bit6_ff, link_off_ff, reconnect_ff};
        assign clash_vec[p] = port_live_in[p].clash;
        assign rx_vec[p] = port_live_in[p].rx_source;
        assign iso_vec[p] = port_live_in[p].isolated;
        assign full_vec[p] = counts[p] == `COUNT_FULL;
        assign half_vec[p] = counts[p][15];
        assign low_vec[p] = |counts[p];
        assign found_vec[p] = |records[p];

        event_tracker u_tracker (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .count_pulse_in(count_evt_in[p]),
            .flags_in(record_evt_in[p]),
            .clear_record_in(clear_rec),
            .clear_count_in(clear_cnt),
            .count_out(counts[p]),
            .record_out(records[p])
        );

        property p_forced_cause;
            @(posedge clk_in) disable iff (!resetn_in)
            reconnect_ff |=> status_bytes[p][5:4] == `CAUSE_FORCED;
        endproperty
        a_forced_cause: assert property (p_forced_cause) // R16
            else $error("forced reconnection did not set cause code");
    end

    // ****************************************
    // Page select
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            page_ff <= `PAGE_RESET;
        end else if (wr_en && idx == `IDX_PAGE_SELECT) begin
            page_ff <= wb_req_in.dat[2:0]; // R18
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    logic [7:0] rd_byte;
    logic [15:0] cnt_word;

    always_comb begin
        rd_byte = 8'h00;
        cnt_word = counts[cnt_port];
        if (idx == `IDX_CHIP_STATUS) begin
            rd_byte = {strap_sync[2], // R7
                strap_sync[1:0], // R6
                !(|iso_vec), // R4
                !babble_lock_in, // R3
                !(|rx_vec), // R2
                !(|clash_vec), // R1
                1'b0}; // R5
        end else if (port_valid) begin
            rd_byte = status_bytes[port_num];
        end else if (idx == `IDX_PAGE_SELECT) begin
            rd_byte = {|full_vec, |half_vec, |low_vec, |found_vec, 1'b0, page_ff};
        end else if (rec_valid) begin
            rd_byte = records[rec_port];
        end else if (cnt_valid) begin
            rd_byte = cnt_hi ? cnt_word[15:8] : cnt_word[7:0]; // R19
        end
    end

    // Unmapped indexes answer with zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dat_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            dat_ff <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_ack_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        hit && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack is not a single cycle after request");

    property p_any_clash;
        @(posedge clk_in) disable iff (!resetn_in)
        wb_ack_out && !wb_req_in.we && idx == `IDX_CHIP_STATUS
            |-> wb_dat_out[1] == !$past(|clash_vec);
    endproperty
    a_any_clash: assert property (p_any_clash) // R1
        else $error("collision summary bit wrong");

    property p_any_rx;
        @(posedge clk_in) disable iff (!resetn_in)
        wb_ack_out && !wb_req_in.we && idx == `IDX_CHIP_STATUS
            |-> wb_dat_out[2] == !$past(|rx_vec);
    endproperty
    a_any_rx: assert property (p_any_rx) // R2
        else $error("receive summary bit wrong");

    property p_babble;
        @(posedge clk_in) disable iff (!resetn_in)
        wb_ack_out && !wb_req_in.we && idx == `IDX_CHIP_STATUS
            |-> wb_dat_out[3] != $past(babble_lock_in);
    endproperty
    a_babble: assert property (p_babble) // R3
        else $error("babble lock bit wrong");

    property p_any_iso;
        @(posedge clk_in) disable iff (!resetn_in)
        wb_ack_out && !wb_req_in.we && idx == `IDX_CHIP_STATUS
            |-> wb_dat_out[4] == !$past(|iso_vec) && !wb_dat_out[0];
    endproperty
    a_any_iso: assert property (p_any_iso) // R4
        else $error("isolation summary or reserved bit wrong");

    property p_link_off;
        @(posedge clk_in) disable iff (!resetn_in)
        port_wr && wb_req_in.dat[0]
            |=> port_ctl_out[$past(port_num)].link_pulse_off;
    endproperty
    a_link_off: assert property (p_link_off) // R9
        else $error("link pulses not stopped by write");

    property p_reconnect;
        @(posedge clk_in) disable iff (!resetn_in)
        port_wr |=> port_ctl_out[$past(port_num)].reconnect
            == $past(wb_req_in.dat[3]);
    endproperty
    a_reconnect: assert property (p_reconnect) // R14
        else $error("reconnect pulse does not follow written bit");

    property p_port_off;
        @(posedge clk_in) disable iff (!resetn_in)
        port_wr |=> port_ctl_out[$past(port_num)].port_off
            == $past(wb_req_in.dat[7]);
    endproperty
    a_port_off: assert property (p_port_off) // R17
        else $error("port disable not stored");

    property p_page;
        @(posedge clk_in) disable iff (!resetn_in)
        wr_en && idx == `IDX_PAGE_SELECT |=> page_ff == $past(wb_req_in.dat[2:0]);
    endproperty
    a_page: assert property (p_page) // R18
        else $error("page select not stored");

endmodule
`default_nettype wire

// ### testbench/repeater_status_regs_test.sv
// Self-checking bench for the repeater status register bank
`timescale 1ns/100ps
`default_nettype none
`include "repeater_status_defines.svh"

module repeater_status_regs_test;
    import repeater_status_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    wb_req_type wb_req_in = '0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    port_live_type [12:0] port_live_in = '0;
    logic babble_lock_in = 1'b0;
    logic [12:0][7:0] record_evt_in = '0;
    logic [12:0] count_evt_in = '0;
    logic [1:0] transceiver_sel_in = 2'h2;
    logic bus_polarity_select_in = 1'b1;
    port_ctl_type [12:0] port_ctl_out;
    int n_fail = 0;
    int cmp_count = 0;
    int recon_n = 0;

    always #50 clk_in = ~clk_in;

    repeater_status_regs #(.PORT_COUNT(13)) repeater_status_regs_i (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wb_req_in(wb_req_in),
        .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out),
        .port_live_in(port_live_in),
        .babble_lock_in(babble_lock_in),
        .record_evt_in(record_evt_in),
        .count_evt_in(count_evt_in),
        .transceiver_sel_in(transceiver_sel_in),
        .bus_polarity_select_in(bus_polarity_select_in),
        .port_ctl_out(port_ctl_out)
    );

    // Counts sampled cycles of the reconnect pulse, so a long pulse shows
    always @(posedge clk_in) begin
        if (port_ctl_out[6].reconnect === 1'b1) begin
            recon_n <= recon_n + 1;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("mismatches %0d of %0d compares", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // Classic cycle; waits for ack without assuming its latency
    task automatic wb_cycle(input logic we, input logic [4:0] idx, input logic [7:0] wdat,
                            input logic [3:0] sel, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_req_in.cyc <= 1'b1;
        wb_req_in.stb <= 1'b1;
        wb_req_in.we <= we;
        wb_req_in.adr <= {idx, 2'b00};
        wb_req_in.sel <= sel;
        wb_req_in.dat <= {24'h0, wdat};
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        if (n >= 50) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            n_fail++;
        end
        rdat = wb_dat_out;
        wb_req_in.cyc <= 1'b0;
        wb_req_in.stb <= 1'b0;
        wb_req_in.we <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'h1);
        logic [31:0] unused;
        wb_cycle(1'b1, idx, d, sel, unused);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
        logic [31:0] d;
        wb_cycle(1'b0, idx, 8'h00, 4'h1, d);
        chk(d & {24'hffffff, mask}, {24'h0, exp & mask});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_in);
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        settle();
        // Chip status flags, one cause at a time
        rd(`IDX_CHIP_STATUS, 8'hde);
        port_live_in[2].clash <= 1'b1;
        settle();
        rd(`IDX_CHIP_STATUS, 8'hdc);
        port_live_in[3].rx_source <= 1'b1;
        port_live_in[2].clash <= 1'b0;
        settle();
        rd(`IDX_CHIP_STATUS, 8'hda);
        port_live_in[3].rx_source <= 1'b0;
        babble_lock_in <= 1'b1;
        settle();
        rd(`IDX_CHIP_STATUS, 8'hd6);
        babble_lock_in <= 1'b0;
        port_live_in[4].isolated <= 1'b1;
        settle();
        rd(`IDX_CHIP_STATUS, 8'hce);
        port_live_in[4].isolated <= 1'b0;
        bus_polarity_select_in <= 1'b0;
        transceiver_sel_in <= 2'h1;
        settle();
        rd(`IDX_CHIP_STATUS, 8'h3e);

        // Port live bits; port 1 link bit is never looked at
        port_live_in[2].clash <= 1'b1;
        port_live_in[2].rx_source <= 1'b1;
        port_live_in[2].link_seen <= 1'b1;
        settle();
        rd(5'h03, 8'h0e);
        rd(5'h01, 8'h08, 8'hfe);

        // Writable controls of port 2
        port_live_in[1].link_seen <= 1'b1;
        wr(5'h02, 8'hc1);
        @(posedge clk_in);
        chk({29'h0, port_ctl_out[1].port_off, port_ctl_out[1].port_status_bit6,
             port_ctl_out[1].link_pulse_off}, 32'h7);
        rd(5'h02, 8'hc9);
        wr(5'h02, 8'h00);
        @(posedge clk_in);
        chk({29'h0, port_ctl_out[1].port_off, port_ctl_out[1].port_status_bit6,
             port_ctl_out[1].link_pulse_off}, 32'h0);
        rd(5'h02, 8'h08);

        // Cause codes, cause set ahead of the isolating edge
        for (int c = 0; c < 3; c++) begin
            port_live_in[5 + c].cause <= c[1:0];
            @(posedge clk_in);
            port_live_in[5 + c].isolated <= 1'b1;
            settle();
            rd(5'(6 + c), {2'b00, c[1:0], 4'b0001});
        end

        // Forced reconnection of port 7
        wr(5'h07, 8'h00);
        settle();
        chk(recon_n, 0);
        wr(5'h07, 8'h08);
        settle();
        chk(recon_n, 1);
        port_live_in[6].isolated <= 1'b0;
        settle();
        rd(5'h07, 8'h39);
        wr(5'h07, 8'h00);
        settle();
        chk(recon_n, 1);

        // Page select and unmapped places
        rd(5'h0e, 8'h00);
        rd(5'h11, 8'h00);
        wr(`IDX_PAGE_SELECT, {5'h0, `PAGE_RECORD});
        rd(`IDX_PAGE_SELECT, {5'h0, `PAGE_RECORD}, 8'h07);
        wr(`IDX_PAGE_SELECT, {5'h0, `PAGE_COUNT_B}, 4'h2);
        rd(`IDX_PAGE_SELECT, {5'h0, `PAGE_RECORD}, 8'h07);

        // Sticky record cleared by its read
        @(posedge clk_in);
        record_evt_in[0] <= 8'h81;
        @(posedge clk_in);
        record_evt_in[0] <= 8'h00;
        @(posedge clk_in);
        record_evt_in[12] <= 8'h24;
        @(posedge clk_in);
        record_evt_in[12] <= 8'h00;
        rd(`IDX_RECORD_FIRST, 8'h81);
        rd(`IDX_RECORD_FIRST, 8'h00);
        rd(`IDX_RECORD_LAST, 8'h24);
        rd(`IDX_CHIP_STATUS, 8'h28);

        // Counters on both count pages
        @(posedge clk_in);
        count_evt_in[0] <= 1'b1;
        count_evt_in[7] <= 1'b1;
        count_evt_in[6] <= 1'b1;
        repeat (3) @(posedge clk_in);
        count_evt_in[0] <= 1'b0;
        count_evt_in[6] <= 1'b0;
        repeat (2) @(posedge clk_in);
        count_evt_in[7] <= 1'b0;
        wr(`IDX_PAGE_SELECT, {5'h0, `PAGE_COUNT_A});
        rd(`IDX_PAGE_SELECT, 8'h22);
        rd(`IDX_COUNT_FIRST, 8'h03);
        rd(5'h13, 8'h00);
        rd(`IDX_COUNT_FIRST, 8'h00);
        rd(5'h1e, 8'h03);
        rd(`IDX_COUNT_A_LAST, 8'h00);
        wr(`IDX_PAGE_SELECT, {5'h0, `PAGE_COUNT_B});
        rd(`IDX_COUNT_FIRST, 8'h05);
        rd(5'h13, 8'h00);
        wr(`IDX_PAGE_SELECT, {5'h0, `PAGE_RESET});
        rd(`IDX_COUNT_FIRST, 8'h00);
        end_of_test();
    end

endmodule
`default_nettype wire
